// file: verilog/scb_call_unit.sv
// Purpose: Executes the two delayed subroutine calls of the core
// Assumes: Core issues one instruction per INSN_VALID cycle with its address;
//          the general register file answers GPR_SEL in the same cycle
// Notes:   Delay slot handling and restart included
`timescale 1ns/1ps
`include "scb_map.svh"
module scb_call_unit
   import scb_pkg::*;
(
   // Clock and reset
   input  wire logic                   CLK,
   input  wire logic                   SYS_RST,
   // Issued instruction
   input  wire logic                   INSN_VALID,
   input  wire logic [`SCB_INSN_W-1:0] INSN,
   input  wire logic [`SCB_XLEN-1:0]   INSN_PC,
   input  wire logic                   INSN_IS_BRANCH,
   input  wire logic                   OTHER_SLOT_ACTIVE,
   input  wire logic                   SLOT_REEXEC_FAULT,
   // General register read
   output      logic [3:0]             GPR_SEL,
   input  wire logic [`SCB_XLEN-1:0]   GPR_DATA,
   // Return register
   output      logic                   PR_WE,
   output      logic [`SCB_XLEN-1:0]   PR_VALUE,
   // Control transfer and exceptions
   output      logic                   CALL_TAKEN,
   output      logic                   BRANCH_VALID,
   output      logic [`SCB_XLEN-1:0]   BRANCH_TARGET,
   output      logic                   ILLEGAL_SLOT,
   output      logic                   RESTART_VALID,
   output      logic [`SCB_XLEN-1:0]   RESTART_PC,
   output      logic                   IRQ_BLOCK,
   output      logic                   IN_SLOT
);

   scb_regs_t            r;
   scb_regs_t            next_r;
   logic                 is_call;
   logic                 slot_busy;
   logic [`SCB_XLEN-1:0] pc_ahead;

   scb_dec_if dec_bus ();

   // Field decode of the issued word
   assign dec_bus.insn = INSN;

   scb_decoder u_dec (
      .d (dec_bus.dec)
   );

   // Register port follows the field of the word on the bus
   assign GPR_SEL = dec_bus.reg_sel;

   // Next-state logic
   always_comb begin
      next_r          = r;
      next_r.pr_we    = 1'b0;
      next_r.br_valid = 1'b0;
      next_r.illegal  = 1'b0;
      next_r.restart  = 1'b0;
      is_call         = INSN_VALID && (dec_bus.is_rel || dec_bus.is_reg);
      slot_busy       = (r.state == SCB_SLOT) || OTHER_SLOT_ACTIVE;
      // same base for the register form
      pc_ahead        = INSN_PC + `SCB_PC_AHEAD;
      case (r.state)
         SCB_IDLE: begin
            if (is_call && OTHER_SLOT_ACTIVE) begin
               next_r.illegal = 1'b1;
            end else if (is_call) begin
               next_r.pr      = pc_ahead;
               next_r.pr_we   = 1'b1;
               next_r.call_pc = INSN_PC;
               if (dec_bus.is_rel) begin
                  next_r.target = pc_ahead + dec_bus.rel_offset;
               end else begin
                  next_r.target = pc_ahead + GPR_DATA;
               end
               next_r.state = SCB_SLOT;
            end
         end
         SCB_SLOT: begin
            if (SLOT_REEXEC_FAULT) begin
               next_r.restart    = 1'b1;
               next_r.restart_pc = r.call_pc;
               next_r.state      = SCB_IDLE;
            end else if (INSN_VALID && (INSN_IS_BRANCH || is_call)) begin
               next_r.illegal = 1'b1;
               next_r.state   = SCB_IDLE;
            end else if (INSN_VALID) begin
               next_r.br_valid  = 1'b1;
               next_r.br_target = r.target;
               next_r.state     = SCB_IDLE;
            end
         end
         default: begin
            next_r.state = SCB_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Outputs
   assign CALL_TAKEN    = is_call && !slot_busy;
   assign PR_WE         = r.pr_we;
   assign PR_VALUE      = r.pr;
   assign BRANCH_VALID  = r.br_valid;
   assign BRANCH_TARGET = r.br_target;
   assign ILLEGAL_SLOT  = r.illegal;
   assign RESTART_VALID = r.restart;
   assign RESTART_PC    = r.restart_pc;
   assign IRQ_BLOCK     = (r.state == SCB_SLOT);
   assign IN_SLOT       = (r.state == SCB_SLOT);

endmodule

// file: verilog/scb_map.svh
// Purpose: Encodings, field positions and timing counts of the call unit
// Assumes: 16-bit instruction words and a 32-bit address space
// Notes:   Definitions only; included by bare name
`ifndef SCB_MAP_SVH
`define SCB_MAP_SVH

// Data and address width
`define SCB_XLEN          32
// Instruction word width
`define SCB_INSN_W        16
// PC-relative call: top nibble 4'b1011, 12-bit displacement below
`define SCB_REL_OP_HI     15
`define SCB_REL_OP_LO     12
`define SCB_REL_OPCODE    4'hb
`define SCB_DISP_HI       11
`define SCB_DISP_LO       0
`define SCB_DISP_W        12
// Register call: 0000 nnnn 0000 0011
`define SCB_REG_TOP_HI    15
`define SCB_REG_TOP_LO    12
`define SCB_REG_TOP       4'h0
`define SCB_REG_SEL_HI    11
`define SCB_REG_SEL_LO    8
`define SCB_REG_LOW_HI    7
`define SCB_REG_LOW_LO    0
`define SCB_REG_LOW       8'h03
// Distance from the call to the second instruction after it
`define SCB_PC_AHEAD      32'h0000_0004
// Cycles taken by either call form
`define SCB_CALL_CYCLES   2

`endif

// file: verilog/scb_pkg.sv
// Purpose: Types shared by the call unit and its decoder
// Assumes: scb_map.svh provides the widths
// Notes:   Types only
`include "scb_map.svh"
package scb_pkg;

   // Call unit sequence, Gray along idle -> slot
   typedef enum logic [1:0] {
      SCB_IDLE = 2'b00,
      SCB_SLOT = 2'b01
   } scb_state_t;

   // Whole state of the call unit
   typedef struct packed {
      scb_state_t                 state;
      logic [`SCB_XLEN-1:0]       target;
      logic [`SCB_XLEN-1:0]       call_pc;
      logic [`SCB_XLEN-1:0]       pr;
      logic                       pr_we;
      logic                       br_valid;
      logic [`SCB_XLEN-1:0]       br_target;
      logic                       illegal;
      logic                       restart;
      logic [`SCB_XLEN-1:0]       restart_pc;
   } scb_regs_t;

endpackage

// file: verilog/scb_dec_if.sv
// Purpose: Carries an instruction word to the decoder and its fields back
// Assumes: Purely combinational decode
// Notes:   One modport per side
`timescale 1ns/1ps
`include "scb_map.svh"
interface scb_dec_if;
   logic [`SCB_INSN_W-1:0] insn;
   logic                   is_rel;
   logic                   is_reg;
   logic [3:0]             reg_sel;
   logic [`SCB_XLEN-1:0]   rel_offset;

   modport dec  (input insn, output is_rel, is_reg, reg_sel, rel_offset);
   modport core (output insn, input is_rel, is_reg, reg_sel, rel_offset);
endinterface

// file: verilog/scb_decoder.sv
// Purpose: Recognises the two call encodings and extracts their fields
// Assumes: Word arrives already fetched, same clock domain
// Notes:   No state; fields are valid only while the word is
`timescale 1ns/1ps
`include "scb_map.svh"
module scb_decoder
   import scb_pkg::*;
(
   scb_dec_if.dec d
);

   logic [`SCB_DISP_W-1:0] disp;

   // Field extraction and opcode match
   always_comb begin
      disp = d.insn[`SCB_DISP_HI:`SCB_DISP_LO];
      d.is_rel = (d.insn[`SCB_REL_OP_HI:`SCB_REL_OP_LO] == `SCB_REL_OPCODE);
      d.is_reg = (d.insn[`SCB_REG_TOP_HI:`SCB_REG_TOP_LO] == `SCB_REG_TOP)
                 && (d.insn[`SCB_REG_LOW_HI:`SCB_REG_LOW_LO] == `SCB_REG_LOW);
      d.reg_sel = d.insn[`SCB_REG_SEL_HI:`SCB_REG_SEL_LO];
      d.rel_offset = {{(`SCB_XLEN-`SCB_DISP_W-1){disp[`SCB_DISP_W-1]}}, disp, 1'b0};
   end

endmodule

// file: testbench/scb_call_props.sv
// Purpose: Port timing checks on the call unit
// Assumes: One clock, synchronous reset
// Notes:   Bound from the bench
`timescale 1ns/1ps
module scb_call_props (
   // Watched ports
   input wire logic        CLK, SYS_RST, INSN_VALID, INSN_IS_BRANCH,
   input wire logic        OTHER_SLOT_ACTIVE, SLOT_REEXEC_FAULT, PR_WE, CALL_TAKEN,
   input wire logic        BRANCH_VALID, ILLEGAL_SLOT, RESTART_VALID, IRQ_BLOCK, IN_SLOT,
   input wire logic [15:0] INSN,
   input wire logic [31:0] INSN_PC, GPR_DATA, PR_VALUE, BRANCH_TARGET, RESTART_PC,
   input wire logic [3:0]  GPR_SEL
);
   logic [31:0] call_pc;
   logic [31:0] tgt;
   wire is_call = INSN[15:12] == 4'hb || (INSN[15:12] == 4'h0 && INSN[7:0] == 8'h03);
   wire slot_go = IN_SLOT && INSN_VALID && !SLOT_REEXEC_FAULT;
   // Remembers the call address and its destination
   always_ff @(posedge CLK) begin
      if (CALL_TAKEN) begin
         call_pc <= INSN_PC;
         tgt     <= INSN_PC + 32'h4 +
            (INSN[15:12] == 4'hb ? {{19{INSN[11]}}, INSN[11:0], 1'b0} : GPR_DATA);
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   sequence call_s; CALL_TAKEN; endsequence
   sequence pr_s; PR_WE && PR_VALUE == call_pc + 32'h4 && IRQ_BLOCK && IN_SLOT; endsequence
   a_call_pr_write: assert property (call_s |=> pr_s)
      else $error("return write missing");
   a_gpr_select: assert property (GPR_SEL == INSN[11:8])
      else $error("register select wrong");
   a_slot_sees_pr: assert property (IN_SLOT |-> PR_VALUE == call_pc + 32'h4)
      else $error("slot sees old return");
   a_branch_after_slot: assert property (slot_go && !INSN_IS_BRANCH && !is_call
      |=> BRANCH_VALID && !IN_SLOT && !IRQ_BLOCK) else $error("no branch after slot");
   a_branch_dest: assert property (BRANCH_VALID |-> BRANCH_TARGET == tgt)
      else $error("branch target wrong");
   a_slot_illegal: assert property (slot_go && INSN_IS_BRANCH
      |=> ILLEGAL_SLOT && !BRANCH_VALID) else $error("branch in slot accepted");
   a_nested_call: assert property (INSN_VALID && is_call && OTHER_SLOT_ACTIVE && !IN_SLOT
      |=> ILLEGAL_SLOT && !PR_WE) else $error("call in slot accepted");
   a_fault_restart: assert property (IN_SLOT && SLOT_REEXEC_FAULT |=> RESTART_VALID &&
      RESTART_PC == call_pc && !BRANCH_VALID && $stable(PR_VALUE)) else $error("no restart");
endmodule

// file: testbench/scb_call_unit_bench.sv
// Purpose: Random and corner calls through the call unit
// Assumes: Inputs change by non-blocking assignment at the rising edge
// Notes:   Four cases: plain, branch or call in slot, slot fault, nested call
`timescale 1ns/1ps
module scb_call_unit_bench;
   logic clk = 0, rst = 1, iv = 0, ibr = 0, oth = 0, flt = 0;
   logic [15:0] insn = '0;
   logic [31:0] ipc = '0, gpr = '0, pr_val, bt, rpc, pc, r;
   logic [3:0]  sel;
   logic [15:0] w;
   logic [11:0] d;
   logic        pr_we, taken, bv, ill, rv, irq, slot;
   int          errors = 0, check_count = 0, k;
   scb_call_unit scb_call_unit_i (.CLK(clk), .SYS_RST(rst), .INSN_VALID(iv), .INSN(insn),
      .INSN_PC(ipc), .INSN_IS_BRANCH(ibr), .OTHER_SLOT_ACTIVE(oth), .SLOT_REEXEC_FAULT(flt),
      .GPR_SEL(sel), .GPR_DATA(gpr), .PR_WE(pr_we), .PR_VALUE(pr_val), .CALL_TAKEN(taken),
      .BRANCH_VALID(bv), .BRANCH_TARGET(bt), .ILLEGAL_SLOT(ill), .RESTART_VALID(rv),
      .RESTART_PC(rpc), .IRQ_BLOCK(irq), .IN_SLOT(slot));
   // Clock at 40 MHz
   always #12.5 clk = ~clk;
   // Drives one cycle of issue, then lets the edge settle
   task cyc(input logic v, input logic [15:0] iw, input logic [31:0] a,
            input logic b, o, f, input logic [31:0] g);
      @(posedge clk);
      iv <= v; insn <= iw; ipc <= a; ibr <= b; oth <= o; flt <= f; gpr <= g;
      #1;
   endtask
   task chk(input string n, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   // Expected destination of either call form
   function logic [31:0] dest(input logic [15:0] cw, input logic [31:0] a, v);
      dest = a + 32'h4 + (cw[15:12] == 4'hb ? {{19{cw[11]}}, cw[11:0], 1'b0} : v);
   endfunction
   task give_verdict;
      if (errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      give_verdict;
   end
   // Main sequence: first four passes are corner cases
   initial begin
      void'($urandom(32'hce8c));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 64; i++) begin
         k  = i < 4 ? i : $urandom % 4;
         d  = i < 4 ? (i[0] ? 12'h7ff : 12'h800) : 12'($urandom);
         w  = ($urandom % 2) ? {4'hb, d} : {4'h0, 4'($urandom), 8'h03};
         pc = $urandom & 32'hffff_fffe;
         r  = $urandom;
         cyc(1, w, pc, 0, k == 3, 0, r);
         chk("taken", k != 3, taken);
         chk("select", w[11:8], sel);
         cyc(k != 3, (k == 1 && !i[2]) ? {4'hb, d} : {4'h6, d}, pc + 32'h2,
             k == 1 && i[2], 0, k == 2, $urandom);
         if (k == 3) begin
            chk("illegal", 1, ill);
            chk("pr_we", 0, pr_we);
         end else begin
            chk("pr_we", 1, pr_we);
            chk("pr_value", pc + 32'h4, pr_val);
            chk("irq_block", 1, irq);
         end
         cyc(0, 16'h0, 32'h0, 0, 0, 0, $urandom);
         if (k == 0) begin
            chk("branch", 1, bv);
            chk("target", dest(w, pc, r), bt);
            chk("in_slot", 0, slot);
         end else if (k == 1) begin
            chk("illegal", 1, ill);
            chk("branch", 0, bv);
         end else if (k == 2) begin
            chk("restart", 1, rv);
            chk("restart_pc", pc, rpc);
            chk("pr_kept", pc + 32'h4, pr_val);
         end
      end
      give_verdict;
   end
endmodule
bind scb_call_unit scb_call_props scb_call_props_i (.*);
